/* pkg/pso_map.svh */
`ifndef PSO_MAP_SVH
`define PSO_MAP_SVH

// Register byte offsets
`define PSO_OFF_FUNC 8'h10
`define PSO_OFF_DIR 8'h14
`define PSO_OFF_LATCH 8'h18
`define PSO_OFF_SET 8'h1c
`define PSO_OFF_CLR 8'h20
`define PSO_OFF_LEVEL 8'h24
`define PSO_OFF_STAT 8'h28

// Reset value of every register
`define PSO_RST_ZERO 32'h0000_0000

// Implemented bit groups of the alias and latch words
`define PSO_CTRL_MASK 32'hfe00_0000
`define PSO_LO_MASK 32'h0000_00ff
`define PSO_HI_MASK 32'h0000_ff00

// Status register field: reserved-bit write seen
`define PSO_STAT_RSVD 0
`define PSO_STAT_MASK 32'h0000_0001

// Data pin counts of the two variants
`define PSO_PINS_SMALL 8
`define PSO_PINS_LARGE 16
`endif

/* pkg/pso_pkg.sv */
package pso_pkg;

  // One register bus request, as the master presents it
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pso_req_t;

  // Register selected by a decoded address
  typedef enum logic [2:0] {
    PSO_SEL_NONE,
    PSO_SEL_FUNC,
    PSO_SEL_DIR,
    PSO_SEL_LATCH,
    PSO_SEL_SET,
    PSO_SEL_CLR,
    PSO_SEL_LEVEL,
    PSO_SEL_STAT
  } pso_sel_t;

  // Per-bit latch update command
  typedef struct packed {
    logic load;
    logic set;
    logic clr;
  } pso_bit_cmd_t;

endpackage

/* hw/pso_pin_bit.sv */
`include "pso_map.svh"
module pso_pin_bit
  import pso_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input pso_bit_cmd_t cmd,
  input wire logic wdata_bit,
  input wire logic func_bit,
  input wire logic dir_bit,
  output logic latch_q,
  output logic pin_out,
  output logic pin_oe_n
);

  logic latch_d;

  // Next latch value: only a written one acts on set or clear
  always_comb begin
    latch_d = latch_q;
    if (cmd.load) begin
      latch_d = wdata_bit;
    end else if (cmd.set && wdata_bit) begin
      latch_d = 1'b1;
    end else if (cmd.clr && wdata_bit) begin
      latch_d = 1'b0;
    end
  end

  // Latch flop, zero after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Pad drive: latch reaches the pin only as general-purpose output
  assign pin_out = latch_q;
  assign pin_oe_n = ~(func_bit & dir_bit);

endmodule

/* hw/pso_regbus.sv */
`include "pso_map.svh"
module pso_regbus
  import pso_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input pso_req_t req,
  input wire logic [31:0] rd_value,
  output pso_sel_t sel,
  output logic wr_en,
  output logic rd_en,
  output logic [31:0] rdata_q
);

  logic [31:0] rdata_d;

  // Address decode; unmapped offsets select nothing
  always_comb begin
    unique case (req.addr)
      `PSO_OFF_FUNC: sel = PSO_SEL_FUNC;
      `PSO_OFF_DIR: sel = PSO_SEL_DIR;
      `PSO_OFF_LATCH: sel = PSO_SEL_LATCH;
      `PSO_OFF_SET: sel = PSO_SEL_SET;
      `PSO_OFF_CLR: sel = PSO_SEL_CLR;
      `PSO_OFF_LEVEL: sel = PSO_SEL_LEVEL;
      `PSO_OFF_STAT: sel = PSO_SEL_STAT;
      default: sel = PSO_SEL_NONE;
    endcase
  end

  // Strobes qualified by a mapped address
  assign wr_en = req.wr && (sel != PSO_SEL_NONE);
  assign rd_en = req.rd && (sel != PSO_SEL_NONE);

  // Read data stands only in the cycle after the read strobe
  always_comb begin
    rdata_d = `PSO_RST_ZERO;
    if (rd_en) begin
      rdata_d = rd_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `PSO_RST_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule

/* hw/pso_top.sv */
// The implementer's own choice: the plain strobed port.
`include "pso_map.svh"
module pso_top
  import pso_pkg::*;
#(
  parameter int DATA_PINS = `PSO_PINS_LARGE
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic [31:0] PIN_IN,
  output logic [31:0] PIN_OUT,
  output logic [31:0] PIN_OE_N
);

  // Only the two documented variants can be served
  if (DATA_PINS != `PSO_PINS_SMALL && DATA_PINS != `PSO_PINS_LARGE) begin
    $error("pso_top: DATA_PINS must be 8 or 16");
  end

  // Bits that exist on this variant; the rest behave as reserved
  localparam logic [31:0] HI_PART =
    (DATA_PINS == `PSO_PINS_LARGE) ? `PSO_HI_MASK : `PSO_RST_ZERO;
  localparam logic [31:0] IMPL_MASK =
    `PSO_CTRL_MASK | `PSO_LO_MASK | HI_PART;

  pso_req_t req;
  pso_sel_t sel;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_value;
  logic [31:0] wdata_impl;
  logic rsvd_hit;

  logic [31:0] func_q;
  logic [31:0] func_d;
  logic [31:0] dir_q;
  logic [31:0] dir_d;
  logic [31:0] level_q;
  logic [31:0] level_d;
  logic rsvd_seen_q;
  logic rsvd_seen_d;

  logic [31:0] latch_vec;
  pso_bit_cmd_t bit_cmd;

  // Gather the bus signals into one request
  assign req.addr = REG_ADDR;
  assign req.wdata = REG_WDATA;
  assign req.wr = REG_WR;
  assign req.rd = REG_RD;

  // Decode and read-data register
  pso_regbus u_regbus (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .req(req),
    .rd_value(rd_value),
    .sel(sel),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata_q(REG_RDATA)
  );

  // Reserved and absent bits are stripped before the function, direction and latch state sees them
  assign wdata_impl = req.wdata & IMPL_MASK;

  // Alias and latch writes of the latch word, one kind per cycle
  always_comb begin
    bit_cmd.load = wr_en && (sel == PSO_SEL_LATCH);
    bit_cmd.set = wr_en && (sel == PSO_SEL_SET);
    bit_cmd.clr = wr_en && (sel == PSO_SEL_CLR);
  end

  // Function select and direction next values
  always_comb begin
    func_d = func_q;
    dir_d = dir_q;
    if (wr_en && sel == PSO_SEL_FUNC) begin
      func_d = wdata_impl;
    end
    if (wr_en && sel == PSO_SEL_DIR) begin
      dir_d = wdata_impl;
    end
  end

  // Function select and direction registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      func_q <= `PSO_RST_ZERO;
      dir_q <= `PSO_RST_ZERO;
    end else begin
      func_q <= func_d;
      dir_q <= dir_d;
    end
  end

  // One latch cell per implemented pin; absent pins stay undriven
  for (genvar i = 0; i < 32; i++) begin : g_pin
    if (IMPL_MASK[i]) begin : g_impl
      pso_pin_bit u_bit (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .cmd(bit_cmd),
        .wdata_bit(wdata_impl[i]),
        .func_bit(func_q[i]),
        .dir_bit(dir_q[i]),
        .latch_q(latch_vec[i]),
        .pin_out(PIN_OUT[i]),
        .pin_oe_n(PIN_OE_N[i])
      );
    end else begin : g_absent
      assign latch_vec[i] = 1'b0;
      assign PIN_OUT[i] = 1'b0;
      assign PIN_OE_N[i] = 1'b1;
    end
  end

  // Pin levels, taken as synchronous to the clock
  always_comb begin
    level_d = PIN_IN & IMPL_MASK;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      level_q <= `PSO_RST_ZERO;
    end else begin
      level_q <= level_d;
    end
  end

  // Flags a write, other than to level or status, carrying ones in reserved or absent bits
  assign rsvd_hit = wr_en && (sel != PSO_SEL_STAT) &&
                    (sel != PSO_SEL_LEVEL) &&
                    ((req.wdata & ~IMPL_MASK) != `PSO_RST_ZERO);

  // Sticky status: a new hit wins over a write-one clear
  always_comb begin
    rsvd_seen_d = rsvd_seen_q;
    if (wr_en && sel == PSO_SEL_STAT &&
        req.wdata[`PSO_STAT_RSVD]) begin
      rsvd_seen_d = 1'b0;
    end
    if (rsvd_hit) begin
      rsvd_seen_d = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rsvd_seen_q <= 1'b0;
    end else begin
      rsvd_seen_q <= rsvd_seen_d;
    end
  end

  // Read mux; the aliases read back the latch, reserved bits as zero
  always_comb begin
    rd_value = `PSO_RST_ZERO;
    unique case (sel)
      PSO_SEL_FUNC: rd_value = func_q;
      PSO_SEL_DIR: rd_value = dir_q;
      PSO_SEL_LATCH: rd_value = latch_vec;
      PSO_SEL_SET: rd_value = latch_vec & IMPL_MASK;
      PSO_SEL_CLR: rd_value = latch_vec & IMPL_MASK;
      PSO_SEL_LEVEL: rd_value = level_q;
      PSO_SEL_STAT: begin
        rd_value[`PSO_STAT_RSVD] = rsvd_seen_q;
      end
      PSO_SEL_NONE: rd_value = `PSO_RST_ZERO;
    endcase
  end

endmodule

/* test/pso_top_props.sv */
`include "pso_map.svh"
module pso_top_props
  import pso_pkg::*;
#(
  parameter int DATA_PINS = 16
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic [31:0] PIN_IN,
  input wire logic [31:0] PIN_OUT,
  input wire logic [31:0] PIN_OE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] IMPL =
    (DATA_PINS == 16) ? 32'hfe00ffff : 32'hfe0000ff;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Decoded alias writes and reads
  wire logic set_wr = REG_WR && REG_ADDR == 8'h1c;
  wire logic clr_wr = REG_WR && REG_ADDR == 8'h20;
  wire logic al_rd = REG_RD && (REG_ADDR == 8'h1c || REG_ADDR == 8'h20);
  property p_set;
    set_wr |=> (PIN_OUT & $past(REG_WDATA) & IMPL) ==
      ($past(REG_WDATA) & IMPL);
  endproperty
  a_set: assert property (p_set) else $error("set bit not raised");
  property p_clr;
    clr_wr |=> (PIN_OUT & $past(REG_WDATA) & IMPL) == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear bit not lowered");
  property p_keep;
    set_wr || clr_wr |=>
      ((PIN_OUT ^ $past(PIN_OUT)) & ~$past(REG_WDATA)) == 32'h0;
  endproperty
  a_keep: assert property (p_keep) else $error("untouched bit moved");
  property p_oe;
    set_wr || clr_wr |=> $stable(PIN_OE_N);
  endproperty
  a_oe: assert property (p_oe) else $error("alias changed enables");
  property p_rsvd;
    (PIN_OUT & ~IMPL) == 32'h0 && (PIN_OE_N | IMPL) == 32'hffffffff;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("absent pin active");
  property p_rd;
    al_rd |=> REG_RDATA == ($past(PIN_OUT) & IMPL);
  endproperty
  a_rd: assert property (p_rd) else $error("alias read wrong");
  property p_rd_rsvd;
    REG_RDATA[24:16] == 9'h000;
  endproperty
  a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved read");
  property p_drop;
    (set_wr || clr_wr) && (REG_WDATA & IMPL) == 32'h0 |=> $stable(PIN_OUT);
  endproperty
  a_drop: assert property (p_drop) else $error("reserved latched");
  c_set: cover property (set_wr ##2 clr_wr);
  c_clr: cover property (clr_wr);
  c_rd: cover property (al_rd);
endmodule
bind pso_top pso_top_props #(.DATA_PINS(DATA_PINS)) u_props (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
  .PIN_OE_N(PIN_OE_N));

/* test/tb.sv */
`include "pso_map.svh"
module tb;
  import pso_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] M = 32'hfe00ffff;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, pin_in = 32'h0, reg_rdata, pin_out, pin_oe_n;
  logic [31:0] lat = 0, fn = 0, dr = 0, d;
  int fails = 0, compares = 0, op;
  logic hold = 1'b0;
  pso_top dut (.REF_CLK(ref_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE_N(pin_oe_n));
  // Free-running clock and random pin levels
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (!hold) pin_in <= $urandom;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One-cycle write, then pins against the model
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 0;
    #1;
    cmp(pin_out, lat);
    cmp(pin_oe_n, ~(fn & dr));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 0;
    #1;
    cmp(reg_rdata, exp);
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    fails++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'h05624208));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1;
    rd(8'h20, 32'h0);
    rd(8'h1c, 32'h0);
    for (int i = 0; i < 60; i++) begin
      op = $urandom_range(4);
      d = $urandom & M;
      if (op == 0) lat = lat | d;
      if (op == 1) lat = lat & ~d;
      if (op == 2) fn = d;
      if (op == 3) dr = d;
      if (op == 4) lat = d;
      wr(op == 0 ? 8'h1c : op == 1 ? 8'h20 : op == 2 ? `PSO_OFF_FUNC :
        op == 3 ? `PSO_OFF_DIR : `PSO_OFF_LATCH, d);
      if (i % 8 == 0) rd(8'h20, lat);
      if (i % 8 == 4) begin
        rd(`PSO_OFF_FUNC, fn);
        rd(`PSO_OFF_DIR, dr);
      end
    end
    wr(8'h1c, 32'h01ff0000);
    wr(8'h20, 32'h01ff0000);
    rd(8'h1c, lat);
    rd(`PSO_OFF_STAT, 32'h1);
    wr(`PSO_OFF_STAT, 32'h1);
    rd(`PSO_OFF_STAT, 32'h0);
    hold = 1'b1;
    rd(`PSO_OFF_LEVEL, pin_in & M);
    hold = 1'b0;
    wr(8'hfc, 32'hffffffff);
    rd(8'hfc, 32'h0);
    lat = M;
    wr(8'h1c, 32'hffffffff);
    lat = 32'h0;
    wr(8'h20, 32'hffffffff);
    give_verdict;
  end
endmodule
